/* logic/epsfm_pkg.sv */
package epsfm_pkg;
  // ==========================================================
  // Sizes and limits
  localparam int NPORT = 8;
  localparam int LEN_W = 11;
  localparam logic [10:0] MAX_FRAME_BYTES = 11'h05f2;
  localparam logic [10:0] MIN_FRAME_BYTES = 11'h0040;
  localparam int TABLE_DEPTH = 1000;
  localparam logic [7:0] AGE_LIMIT_TICKS = 8'h1e;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int LINK_TIMEOUT_MS = 100;
  localparam int LINK_TIMEOUT_CYCLES = CLK_HZ / 1000 * LINK_TIMEOUT_MS;
  localparam int BLINK_MS = 125;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  // ==========================================================
  // Register map
  localparam logic [11:0] ADDR_CTRL = 12'h0000;
  localparam logic [11:0] ADDR_STATUS = 12'h0004;
  localparam logic [11:0] ADDR_COUNT = 12'h0008;
  localparam logic [11:0] ADDR_DROPS = 12'h000c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_LEARN_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam int STAT_POL_LSB = 8;
  localparam int STAT_FAULT_BIT = 16;
  localparam int STAT_FULL_BIT = 17;
  // ==========================================================
  // Frame engine states
  typedef enum logic [4:0] {
    S_INIT = 5'b00001,
    S_RX = 5'b00010,
    S_LOOK = 5'b00100,
    S_LEARN = 5'b01000,
    S_SEND = 5'b10000
  } epsfm_state_e;
endpackage : epsfm_pkg

/* logic/epsfm_top.sv */
// Operation
// - Store each whole frame and check it before any byte goes out.
// - Drop frames above 1522 bytes and frames with a failed CRC.
// - Drop fragments below 64 bytes.
// - Learn each frame's source address against its ingress port.
// - Send to a port only if destination unknown, multicast, or learnt there.
// - Address table holds up to 1000 learnt entries.
// - Entries older than 30 seconds are removed.
// - A restart clears all learnt entries.
// - Tagged frames leave with tag and contents unchanged.
// - Never transmit on a port that receives no link pulses.
// - No pulses from an empty port or dead partner means link down.
// - Detect swapped receive polarity and invert automatically.
// - Both supplies below threshold reset the engine; initialise on leaving.
// - Each supply LED lit while its supply is present.
// - Fault LED lit exactly while the fault contact is open.
// - Port LED dark without link, green with link, yellow flashing on receive.
// - Eight mask switches keep a port's link out of the fault contact.
// - Fault contact closed normally, open on any fault.
// - Contact opens when either supply input fails.
// - Contact opens on loss of the internal logic rail.
// - Contact opens when any unmasked port has a bad link.
`timescale 1ns/1ps
module epsfm_top #(
  parameter int TABLE_DEPTH = epsfm_pkg::TABLE_DEPTH,
  parameter int TICK_CYCLES = epsfm_pkg::TICK_CYCLES,
  parameter int LINK_CYCLES = epsfm_pkg::LINK_TIMEOUT_CYCLES,
  parameter int BLINK_CYCLES = epsfm_pkg::BLINK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic [7:0] rx_data,
  input wire logic [2:0] rx_port,
  input wire logic rx_crc_ok,
  output logic rx_ready,
  output logic tx_valid,
  output logic tx_last,
  output logic [7:0] tx_data,
  output logic [7:0] tx_port_mask,
  input wire logic tx_ready,
  input wire logic [7:0] link_pulse_pos,
  input wire logic [7:0] link_pulse_neg,
  input wire logic supply_one_ok,
  input wire logic supply_two_ok,
  input wire logic logic_rail_ok,
  input wire logic [7:0] link_report_mask_switches,
  output logic [7:0] rx_invert,
  output logic [7:0] port_link_up,
  output logic supply_one_led,
  output logic supply_two_led,
  output logic fault_led,
  output logic fault_contact_closed,
  output logic [7:0] port_activity_led_green,
  output logic [7:0] port_activity_led_yellow
);
  localparam int PW = $clog2(TABLE_DEPTH);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int KW = $clog2(LINK_CYCLES + 1);
  localparam int BW = $clog2(BLINK_CYCLES + 1);
  localparam int SW = 27;

  epsfm_pkg::epsfm_state_e state_reg;
  logic [SW-1:0] sync1_reg, sync2_reg;
  logic [7:0] pos_s, neg_s, pos_d_reg, neg_d_reg, mask_s, link_up;
  logic s1_s, s2_s, rail_s;
  logic [10:0] cnt_reg, len_reg, rd_idx_reg;
  logic over_reg, rx_beat, rx_end, good_end;
  logic [95:0] hdr_reg;
  logic [2:0] in_port_reg, dst_port_reg;
  logic [7:0] frame_mem [epsfm_pkg::MAX_FRAME_BYTES];
  logic [47:0] tbl_mac [TABLE_DEPTH];
  logic [2:0] tbl_port [TABLE_DEPTH];
  logic [7:0] tbl_stamp [TABLE_DEPTH];
  logic tbl_val [TABLE_DEPTH];
  logic [PW-1:0] ptr_reg, src_idx_reg, free_idx_reg, learn_idx;
  logic [PW:0] count_reg;
  logic dst_hit_reg, src_hit_reg, free_found_reg, live, age_clr, learn_new, learn_wr;
  logic [7:0] now_reg, egress_next;
  logic [TW-1:0] tick_cnt_reg;
  logic [BW-1:0] blink_cnt_reg;
  logic tick, blink_tick, blink_reg;
  logic [KW-1:0] link_cnt [epsfm_pkg::NPORT];
  logic [7:0] pol_reg, act_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] drops_reg;
  logic flush, restart, tx_load, mcast, fault_now;

  function automatic logic aged(input logic [7:0] now, input logic [7:0] stamp);
    logic [7:0] diff;
    diff = now - stamp;
    aged = diff >= epsfm_pkg::AGE_LIMIT_TICKS;
  endfunction : aged

  // ==========================================================
  // Input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      pos_d_reg <= '0;
      neg_d_reg <= '0;
    end else begin
      sync1_reg <= {link_pulse_pos, link_pulse_neg, supply_one_ok, supply_two_ok,
                    logic_rail_ok, link_report_mask_switches};
      sync2_reg <= sync1_reg;
      pos_d_reg <= pos_s;
      neg_d_reg <= neg_s;
    end
  end
  assign {pos_s, neg_s, s1_s, s2_s, rail_s, mask_s} = sync2_reg;

  // ==========================================================
  // Time bases
  assign tick = tick_cnt_reg == TW'(TICK_CYCLES - 1);
  assign blink_tick = blink_cnt_reg == BW'(BLINK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
      now_reg <= '0;
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      now_reg <= now_reg + {7'h00, tick};
      blink_cnt_reg <= blink_tick ? '0 : blink_cnt_reg + 1'b1;
      blink_reg <= blink_reg ^ blink_tick;
    end
  end

  // ==========================================================
  // Per-port link, polarity and activity
  for (genvar p = 0; p < epsfm_pkg::NPORT; p++) begin : g_port
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        link_cnt[p] <= '0;
      end else if ((pos_s[p] & ~pos_d_reg[p]) | (neg_s[p] & ~neg_d_reg[p])) begin
        link_cnt[p] <= KW'(LINK_CYCLES);
      end else if (link_cnt[p] != '0) begin
        link_cnt[p] <= link_cnt[p] - 1'b1;
      end
    end
    assign link_up[p] = link_cnt[p] != '0;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pol_reg[p] <= 1'b0;
      end else if (neg_s[p] & ~neg_d_reg[p]) begin
        pol_reg[p] <= 1'b1;
      end else if (pos_s[p] & ~pos_d_reg[p]) begin
        pol_reg[p] <= 1'b0;
      end
    end
    // Set wins over the blink-period clear
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        act_reg[p] <= 1'b0;
      end else if (rx_beat && cnt_reg == '0 && !over_reg && rx_port == 3'(p)) begin
        act_reg[p] <= 1'b1;
      end else if (blink_tick) begin
        act_reg[p] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Indicators and fault contact
  // fault terms
  assign fault_now = !s1_s || !s2_s || !rail_s || |(~link_up & mask_s);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_contact_closed <= 1'b0;
      fault_led <= 1'b1;
      supply_one_led <= 1'b0;
      supply_two_led <= 1'b0;
      port_activity_led_green <= '0;
      port_activity_led_yellow <= '0;
      rx_invert <= '0;
      port_link_up <= '0;
    end else begin
      fault_contact_closed <= !fault_now;
      fault_led <= fault_now;
      supply_one_led <= s1_s;
      supply_two_led <= s2_s;
      port_activity_led_yellow <= link_up & act_reg & {8{blink_reg}};
      port_activity_led_green <= link_up & ~(act_reg & {8{blink_reg}});
      rx_invert <= pol_reg;
      port_link_up <= link_up;
    end
  end

  // ==========================================================
  // Frame engine
  // undervoltage restart
  assign restart = flush || (!s1_s && !s2_s);
  assign rx_ready = state_reg == epsfm_pkg::S_RX;
  assign rx_beat = rx_ready && rx_valid;
  assign rx_end = rx_beat && rx_last;
  assign good_end = rx_end && rx_crc_ok && !over_reg && cnt_reg != epsfm_pkg::MAX_FRAME_BYTES
                    && cnt_reg >= epsfm_pkg::MIN_FRAME_BYTES - 11'h001;
  assign tx_load = !tx_valid || tx_ready;
  assign live = tbl_val[ptr_reg] && !aged(now_reg, tbl_stamp[ptr_reg]);
  assign age_clr = (state_reg == epsfm_pkg::S_RX || state_reg == epsfm_pkg::S_LOOK)
                   && tbl_val[ptr_reg] && aged(now_reg, tbl_stamp[ptr_reg]);
  assign learn_new = ctrl_reg[epsfm_pkg::CTRL_LEARN_BIT] && !src_hit_reg && free_found_reg;
  assign learn_wr = state_reg == epsfm_pkg::S_LEARN
                    && (learn_new || (ctrl_reg[epsfm_pkg::CTRL_LEARN_BIT] && src_hit_reg));
  assign learn_idx = src_hit_reg ? src_idx_reg : free_idx_reg;
  assign mcast = hdr_reg[88];
  always_comb begin
    egress_next = ~(8'h01 << in_port_reg);
    if (dst_hit_reg && !mcast) begin
      egress_next = (dst_port_reg == in_port_reg) ? 8'h00 : (8'h01 << dst_port_reg);
    end
    egress_next = egress_next & link_up;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= epsfm_pkg::S_INIT;
    end else if (restart) begin
      state_reg <= epsfm_pkg::S_INIT;
    end else begin
      unique case (state_reg)
        epsfm_pkg::S_INIT: begin
          if (ptr_reg == PW'(TABLE_DEPTH - 1)) state_reg <= epsfm_pkg::S_RX;
        end
        epsfm_pkg::S_RX: begin
          if (good_end) state_reg <= epsfm_pkg::S_LOOK;
        end
        epsfm_pkg::S_LOOK: begin
          if (ptr_reg == PW'(TABLE_DEPTH - 1)) state_reg <= epsfm_pkg::S_LEARN;
        end
        epsfm_pkg::S_LEARN: begin
          state_reg <= (egress_next != 8'h00) ? epsfm_pkg::S_SEND : epsfm_pkg::S_RX;
        end
        epsfm_pkg::S_SEND: begin
          if (tx_load && rd_idx_reg == len_reg) state_reg <= epsfm_pkg::S_RX;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      over_reg <= 1'b0;
      len_reg <= '0;
      hdr_reg <= '0;
      in_port_reg <= '0;
      drops_reg <= '0;
    end else if (state_reg != epsfm_pkg::S_RX) begin
      cnt_reg <= '0;
      over_reg <= 1'b0;
    end else if (rx_beat) begin
      if (cnt_reg == '0 && !over_reg) in_port_reg <= rx_port;
      if (cnt_reg < 11'd12) hdr_reg <= {hdr_reg[87:0], rx_data};
      if (rx_last) begin
        cnt_reg <= '0;
        over_reg <= 1'b0;
        len_reg <= cnt_reg + 11'h001;
        if (!good_end) drops_reg <= drops_reg + 16'h0001;
      end else if (cnt_reg == epsfm_pkg::MAX_FRAME_BYTES) begin
        over_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 11'h001;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (rx_beat && cnt_reg != epsfm_pkg::MAX_FRAME_BYTES && !over_reg) begin
      frame_mem[cnt_reg] <= rx_data;
    end
  end

  // Lookup and aging share one walking pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= '0;
      dst_hit_reg <= 1'b0;
      src_hit_reg <= 1'b0;
      free_found_reg <= 1'b0;
      dst_port_reg <= '0;
      src_idx_reg <= '0;
      free_idx_reg <= '0;
    end else if (restart || good_end) begin
      ptr_reg <= '0;
      dst_hit_reg <= 1'b0;
      src_hit_reg <= 1'b0;
      free_found_reg <= 1'b0;
    end else if (state_reg != epsfm_pkg::S_LEARN && state_reg != epsfm_pkg::S_SEND) begin
      ptr_reg <= (ptr_reg == PW'(TABLE_DEPTH - 1)) ? '0 : ptr_reg + 1'b1;
      if (state_reg == epsfm_pkg::S_LOOK) begin
        if (live && tbl_mac[ptr_reg] == hdr_reg[95:48]) begin
          dst_hit_reg <= 1'b1;
          dst_port_reg <= tbl_port[ptr_reg];
        end
        if (live && tbl_mac[ptr_reg] == hdr_reg[47:0]) begin
          src_hit_reg <= 1'b1;
          src_idx_reg <= ptr_reg;
        end
        if (!live && !free_found_reg) begin
          free_found_reg <= 1'b1;
          free_idx_reg <= ptr_reg;
        end
      end
    end
  end

  // learn into a table of TABLE_DEPTH
  always_ff @(posedge pclk) begin
    if (learn_wr) begin
      tbl_mac[learn_idx] <= hdr_reg[47:0];
      tbl_port[learn_idx] <= in_port_reg;
      tbl_stamp[learn_idx] <= now_reg;
    end
  end

  always_ff @(posedge pclk) begin
    if (state_reg == epsfm_pkg::S_INIT || age_clr) begin
      tbl_val[ptr_reg] <= 1'b0;
    end else if (learn_wr) begin
      tbl_val[learn_idx] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (state_reg == epsfm_pkg::S_INIT) begin
      count_reg <= '0;
    end else if (age_clr) begin
      count_reg <= count_reg - 1'b1;
    end else if (state_reg == epsfm_pkg::S_LEARN && learn_new) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Output stage; tx data comes straight from the frame store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_data <= '0;
      tx_port_mask <= '0;
      rd_idx_reg <= '0;
    end else if (state_reg == epsfm_pkg::S_LEARN) begin
      tx_port_mask <= egress_next;
      rd_idx_reg <= '0;
    end else if (state_reg == epsfm_pkg::S_SEND && tx_load) begin
      if (rd_idx_reg != len_reg) begin
        tx_valid <= 1'b1;
        tx_data <= frame_mem[rd_idx_reg];
        tx_last <= rd_idx_reg == len_reg - 11'h001;
        rd_idx_reg <= rd_idx_reg + 11'h001;
      end else begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
    end else if (state_reg != epsfm_pkg::S_SEND) begin
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != epsfm_pkg::ADDR_CTRL
                   && paddr != epsfm_pkg::ADDR_STATUS && paddr != epsfm_pkg::ADDR_COUNT
                   && paddr != epsfm_pkg::ADDR_DROPS;
  assign flush = psel && penable && pwrite && paddr == epsfm_pkg::ADDR_CTRL
                 && pwdata[epsfm_pkg::CTRL_FLUSH_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= epsfm_pkg::CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == epsfm_pkg::ADDR_CTRL) begin
      ctrl_reg <= {31'h0000_0000, pwdata[epsfm_pkg::CTRL_LEARN_BIT]};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      unique case (paddr)
        epsfm_pkg::ADDR_CTRL: prdata <= ctrl_reg;
        epsfm_pkg::ADDR_STATUS: prdata <= {14'h0000, count_reg == (PW+1)'(TABLE_DEPTH),
                                          fault_now, pol_reg, link_up};
        epsfm_pkg::ADDR_COUNT: prdata <= 32'(count_reg);
        epsfm_pkg::ADDR_DROPS: prdata <= {16'h0000, drops_reg};
        default: prdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_flush_done;
    (state_reg == epsfm_pkg::S_INIT) ##1 (count_reg == '0);
  endsequence
  property p_good_look;
    good_end && !restart |=> state_reg == epsfm_pkg::S_LOOK;
  endproperty
  a_good_look: assert property (p_good_look) else $error("valid frame not looked up");
  property p_crc_drop;
    rx_end && !rx_crc_ok |=> state_reg != epsfm_pkg::S_LOOK;
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("bad crc frame kept");
  property p_frag_drop;
    rx_end && cnt_reg < epsfm_pkg::MIN_FRAME_BYTES - 11'h001 |=> state_reg != epsfm_pkg::S_LOOK;
  endproperty
  a_frag_drop: assert property (p_frag_drop) else $error("fragment kept");
  property p_unicast;
    state_reg == epsfm_pkg::S_LEARN && dst_hit_reg && !mcast && egress_next != 8'h00
      |=> tx_port_mask == (8'h01 << $past(dst_port_reg));
  endproperty
  a_unicast: assert property (p_unicast) else $error("unicast to wrong port");
  property p_no_link_tx;
    state_reg == epsfm_pkg::S_LEARN |=> (tx_port_mask & ~$past(link_up)) == 8'h00;
  endproperty
  a_no_link_tx: assert property (p_no_link_tx) else $error("egress on dead link");
  property p_flush;
    flush |=> s_flush_done;
  endproperty
  a_flush: assert property (p_flush) else $error("restart left entries");
  property p_full_skip;
    state_reg == epsfm_pkg::S_LEARN && !src_hit_reg && !free_found_reg |=> $stable(count_reg);
  endproperty
  a_full_skip: assert property (p_full_skip) else $error("learnt into full table");
  property p_supply_fault;
    !s1_s || !s2_s |=> !fault_contact_closed && fault_led;
  endproperty
  a_supply_fault: assert property (p_supply_fault) else $error("supply loss not flagged");
  property p_link_fault;
    |(~link_up & mask_s) |=> !fault_contact_closed;
  endproperty
  a_link_fault: assert property (p_link_fault) else $error("link fault not flagged");
  property p_dark_led;
    1'b1 |=> ((port_activity_led_green | port_activity_led_yellow) & ~$past(link_up)) == 8'h00;
  endproperty
  a_dark_led: assert property (p_dark_led) else $error("port lamp lit without link");
  property p_pol;
    neg_s[0] && !neg_d_reg[0] |=> ##1 rx_invert[0];
  endproperty
  a_pol: assert property (p_pol) else $error("polarity swap missed");
endmodule : epsfm_top

/* bench/epsfm_far_end.sv */
`timescale 1ns/1ps
module epsfm_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] link_en,
  input wire logic [7:0] swap,
  output logic [7:0] link_pulse_pos,
  output logic [7:0] link_pulse_neg,
  output logic tx_ready
);
  logic [6:0] cnt_reg;
  // ==========================================
  // Link test pulses, one every 100 cycles
  // only powered partners pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= (cnt_reg == 7'h63) ? 7'h00 : cnt_reg + 7'h01;
    end
  end
  // a swapped pair shows on the other comparator
  assign link_pulse_pos = (cnt_reg < 7'h02) ? (link_en & ~swap) : 8'h00;
  assign link_pulse_neg = (cnt_reg < 7'h02) ? (link_en & swap) : 8'h00;
  // ==========================================
  // Slow receiver, stalls every other cycle to exercise the hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ~tx_ready;
    end
  end
endmodule : epsfm_far_end

/* bench/eight_port_switch_forwarding_monitor_tb_top.sv */
`timescale 1ns/1ps
module eight_port_switch_forwarding_monitor_tb_top;
  logic pclk, presetn, psel, penable, pwrite, rx_valid, rx_last, rx_crc_ok, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data, tx_port_mask, pos, neg, sw, rx_invert, link_up, grn, yel;
  logic [7:0] link_en, swap, mask_seen;
  logic [2:0] rx_port;
  logic s1, s2, rail, led1, led2, fled, fcc;
  logic [7:0] txq[$];
  int fail_count, check_count, last_at;

  epsfm_top #(.TABLE_DEPTH(16), .TICK_CYCLES(500), .LINK_CYCLES(200), .BLINK_CYCLES(50)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_data(rx_data), .rx_port(rx_port),
    .rx_crc_ok(rx_crc_ok), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_data(tx_data), .tx_port_mask(tx_port_mask), .tx_ready(tx_ready),
    .link_pulse_pos(pos), .link_pulse_neg(neg), .supply_one_ok(s1), .supply_two_ok(s2),
    .logic_rail_ok(rail), .link_report_mask_switches(sw), .rx_invert(rx_invert),
    .port_link_up(link_up), .supply_one_led(led1), .supply_two_led(led2),
    .fault_led(fled), .fault_contact_closed(fcc), .port_activity_led_green(grn),
    .port_activity_led_yellow(yel));
  epsfm_far_end u_far (.pclk(pclk), .presetn(presetn), .link_en(link_en), .swap(swap),
    .link_pulse_pos(pos), .link_pulse_neg(neg), .tx_ready(tx_ready));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (txq.size() == 0) mask_seen = tx_port_mask;
      if (tx_last === 1'b1) last_at = txq.size();
      txq.push_back(tx_data);
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] pat(int i, logic [7:0] dst, logic [2:0] port);
    return (i < 6) ? dst : (i < 12) ? {5'h02, port} : (i == 12) ? 8'h81 : i[7:0];
  endfunction : pat

  // Byte 12 is a tag marker, so tagged frames must come out intact
  task automatic frame(input logic [2:0] port, input logic [7:0] dst, input int len,
                       input logic crc, input logic [7:0] exp_mask);
    int n;
    txq.delete();
    last_at = -1;
    n = (exp_mask == 8'h00) ? 0 : len;
    @(posedge pclk);
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_data <= pat(i, dst, port);
      rx_port <= port;
      rx_last <= (i == len - 1);
      rx_crc_ok <= crc;
      do @(posedge pclk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    for (int k = 0; k < 4000 && txq.size() < n; k++) @(posedge pclk);
    repeat (50) @(posedge pclk);
    check("tx_bytes", n, txq.size());
    if (n > 0 && txq.size() == n) begin
      check("tx_mask", exp_mask, mask_seen);
      check("tx_last", n - 1, last_at);
      for (int i = 0; i < n; i++) check("tx_data", pat(i, dst, port), txq[i]);
    end
  endtask : frame

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {rx_valid, rx_last, rx_crc_ok, rx_data, rx_port} = 14'h0000;
    {s1, s2, rail} = 3'h7;
    sw = 8'hff;
    link_en = 8'h7f;
    swap = 8'h05;
    repeat (12) @(posedge pclk);
    check("contact_reset", 1'b0, fcc);
    check("fault_led_reset", 1'b1, fled);
    presetn <= 1'b1;
    repeat (400) @(posedge pclk);
    check("link_up", 8'h7f, link_up);
    check("rx_invert", 8'h05, rx_invert);
    check("supply_leds", 2'h3, {led1, led2});
    check("port_leds", 16'h7f00, {grn, yel});
    check("contact_link", 2'h1, {fcc, fled});
    apb(1'b0, epsfm_pkg::ADDR_STATUS, 32'h0000_0000);
    check("status", 32'h0001_057f, rd);
    sw <= 8'h7f;
    repeat (10) @(posedge pclk);
    check("contact_masked", 2'h2, {fcc, fled});
    s2 <= 1'b0;
    repeat (10) @(posedge pclk);
    check("supply_fault", 3'h2, {fcc, fled, led2});
    s2 <= 1'b1;
    rail <= 1'b0;
    repeat (10) @(posedge pclk);
    check("rail_fault", 2'h1, {fcc, fled});
    rail <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, epsfm_pkg::ADDR_CTRL, 32'h0000_0000);
    check("ctrl_reset", epsfm_pkg::CTRL_RESET, rd);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped_err", 1'b1, e);
    frame(3'h0, 8'hff, 64, 1'b1, 8'h7e);
    apb(1'b0, epsfm_pkg::ADDR_COUNT, 32'h0000_0000);
    check("count", 32'h0000_0001, rd);
    frame(3'h1, 8'h10, 64, 1'b1, 8'h01);
    frame(3'h2, 8'hff, 1522, 1'b1, 8'h7b);
    frame(3'h0, 8'hff, 63, 1'b1, 8'h00);
    frame(3'h0, 8'hff, 64, 1'b0, 8'h00);
    frame(3'h0, 8'hff, 1523, 1'b1, 8'h00);
    apb(1'b0, epsfm_pkg::ADDR_DROPS, 32'h0000_0000);
    check("drops", 32'h0000_0003, rd);
    apb(1'b1, epsfm_pkg::ADDR_CTRL, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    apb(1'b0, epsfm_pkg::ADDR_COUNT, 32'h0000_0000);
    check("count_flushed", 32'h0000_0000, rd);
    frame(3'h1, 8'hff, 64, 1'b1, 8'h7d);
    apb(1'b0, epsfm_pkg::ADDR_COUNT, 32'h0000_0000);
    check("count_relearn", 32'h0000_0001, rd);
    // Both supplies low restarts the engine and empties the table
    {s1, s2} <= 2'h0;
    repeat (10) @(posedge pclk);
    {s1, s2} <= 2'h3;
    repeat (40) @(posedge pclk);
    apb(1'b0, epsfm_pkg::ADDR_COUNT, 32'h0000_0000);
    check("count_undervolt", 32'h0000_0000, rd);
    frame(3'h1, 8'hff, 64, 1'b1, 8'h7d);
    // Age limit is 29 to 30 ticks of 500 cycles after learning
    repeat (14000) @(posedge pclk);
    apb(1'b0, epsfm_pkg::ADDR_COUNT, 32'h0000_0000);
    check("count_young", 32'h0000_0001, rd);
    repeat (1200) @(posedge pclk);
    apb(1'b0, epsfm_pkg::ADDR_COUNT, 32'h0000_0000);
    check("count_aged", 32'h0000_0000, rd);
    conclude();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    conclude();
  end
endmodule : eight_port_switch_forwarding_monitor_tb_top
